// file: hdl/pcvec_core.sv
// program counter, page select, return stack and interrupt vectoring
// assumes the decoder drives one step per cycle on the system clock and
// that the interrupt source events are one-cycle pulses on that clock;
// the reset pin and the input-only port come from outside the domain
//
// What this block does
// - fourteen-bit program counter over 16384 words
// - reset loads address zero and fetches there
// - vectors 0004, 0008, 000C for first three
// - slow divider to 0014, timer 1 to 0020
// - fixed priority fast, timer0, port, slow, timer1
// - jump and call use preselected page
// - page move takes immediate or register value
// - sixteen nested levels of calls and interrupts
// - five sources: four internal, one external port
// - each port pin raises port interrupt independently
// - push on call or interrupt, pop on return
// - eight pages of 2048 words, page selects
// - flag taken only when its enable set
`timescale 1ns/10ps

module pcvec_core
  import pcvec_pkg::*;
#(
  parameter int unsigned SYNC_STAGES = 2  // pin synchroniser depth
) (
  // clock and reset
  input  wire logic                CLOCK_I,
  input  wire logic                RSTN_I,
  // reset pin, active low, asynchronous to the clock
  input  wire logic                RESET_PIN_N_I,
  // decoder step
  input  wire pcvec_step_t         STEP_I,
  // internal source events, one-cycle pulses
  input  wire logic                FAST_DIV_EVT_I,
  input  wire logic                SLOW_DIV_EVT_I,
  input  wire logic                TIMER0_EVT_I,
  input  wire logic                TIMER1_EVT_I,
  // input-only port pins and per-pin wake enable
  input  wire logic [PORT_W-1:0]   INTERRUPT_INPUT_PORT_I,
  input  wire logic [PORT_W-1:0]   PORT_PIN_EN_I,
  // flag control from the data path
  input  wire logic [NUM_IRQ-1:0]  INTERRUPT_ENABLE_BITS_I,
  input  wire logic [NUM_IRQ-1:0]  EVENT_FLAG_CLR_I,
  // sequencing outputs
  output logic [PC_W-1:0]          PC_O,
  output logic [PAGE_W-1:0]        INSTRUCTION_PAGE_SELECT_O,
  output logic [NUM_IRQ-1:0]       EVENT_FLAG_BITS_O,
  output logic                     IRQ_TAKEN_O,
  output logic [SP_W:0]            STACK_LEVEL_O
);

  // synchronisers for pins from outside the clock domain
  logic [SYNC_STAGES-1:0] rst_sync_q;            // reset pin chain
  logic [PORT_W-1:0]      port_s1_q;             // port first stage
  logic [PORT_W-1:0]      port_s2_q;             // port second stage
  logic [PORT_W-1:0]      port_prev_q;           // for falling edges

  // sequencing state
  logic [PC_W-1:0]        pc_q;                  // program counter
  logic [PC_W-1:0]        pc_d;                  // next counter value
  logic [PAGE_W-1:0]      page_q;                // selected page
  logic [NUM_IRQ-1:0]     flag_q;                // sticky event flags
  logic [PC_W-1:0]        stack_q [STACK_DEPTH]; // return addresses
  logic [SP_W-1:0]        sp_q;                  // next free slot
  logic [SP_W:0]          level_q;               // occupied levels
  logic                   taken_q;               // registered take pulse

  // combinational helpers
  logic                   sys_rst;               // either reset
  logic [NUM_IRQ-1:0]     pending;               // enabled flags
  logic                   take;                  // take interrupt now
  logic [PC_W-1:0]        vec;                   // winning vector
  logic [NUM_IRQ-1:0]     win;                   // one-hot winner
  logic [PORT_W-1:0]      port_hit;              // per-pin edges
  logic [NUM_IRQ-1:0]     events;                // all source events
  logic                   do_push;               // stack push
  logic                   do_pop;                // stack pop
  logic [PC_W-1:0]        pc_inc;                // next sequential
  logic [PC_W-1:0]        branch;                // paged destination

  // reset pin through two flops; the release is only seen synchronised
  always_ff @(posedge CLOCK_I) begin
    if (!RSTN_I) begin
      rst_sync_q <= '0;
    end else begin
      rst_sync_q <= {rst_sync_q[SYNC_STAGES-2:0], RESET_PIN_N_I};
    end
  end

  assign sys_rst = !RSTN_I || !rst_sync_q[SYNC_STAGES-1];

  // port pins through two flops before any edge logic looks at them
  always_ff @(posedge CLOCK_I) begin
    if (!RSTN_I) begin
      port_s1_q   <= '1;
      port_s2_q   <= '1;
      port_prev_q <= '1;
    end else begin
      port_s1_q   <= INTERRUPT_INPUT_PORT_I;
      port_s2_q   <= port_s1_q;
      port_prev_q <= port_s2_q;
    end
  end

  // each pin fires on its own falling edge, gated by its own enable
  assign port_hit = port_prev_q & ~port_s2_q & PORT_PIN_EN_I;

  // five event sources in priority order
  always_comb begin
    events                = '0;
    events[SRC_FAST_DIV]  = FAST_DIV_EVT_I;
    events[SRC_TIMER0]    = TIMER0_EVT_I;
    events[SRC_PORT]      = |port_hit;
    events[SRC_SLOW_DIV]  = SLOW_DIV_EVT_I;
    events[SRC_TIMER1]    = TIMER1_EVT_I;
  end

  // only enabled flags compete for service
  assign pending = flag_q & INTERRUPT_ENABLE_BITS_I;

  // fixed priority: lowest index wins
  always_comb begin
    win = '0;
    vec = VEC_FAST_DIV;
    if (pending[SRC_FAST_DIV]) begin
      win[SRC_FAST_DIV] = 1'b1;
      vec               = VEC_FAST_DIV;
    end else if (pending[SRC_TIMER0]) begin
      win[SRC_TIMER0]   = 1'b1;
      vec               = VEC_TIMER0;
    end else if (pending[SRC_PORT]) begin
      win[SRC_PORT]     = 1'b1;
      vec               = VEC_PORT;
    end else if (pending[SRC_SLOW_DIV]) begin
      win[SRC_SLOW_DIV] = 1'b1;
      vec               = VEC_SLOW_DIV;
    end else if (pending[SRC_TIMER1]) begin
      win[SRC_TIMER1]   = 1'b1;
      vec               = VEC_TIMER1;
    end
  end

  // interrupts wait for an instruction boundary; a hold step is not one
  assign take = STEP_I.valid && (STEP_I.op != PCVEC_OP_HOLD)
                && (|pending);

  // sticky flags: a new event wins over a clear in the same cycle;
  // hardware clears the served flag when the vector is taken
  always_ff @(posedge CLOCK_I) begin
    if (sys_rst) begin
      flag_q <= '0;
    end else begin
      flag_q <= (flag_q & ~EVENT_FLAG_CLR_I & ~(take ? win : '0))
                | events;
    end
  end

  // sequential address and paged branch destination
  assign pc_inc = pc_q + 14'h0001;
  assign branch = {page_q, STEP_I.target};

  // push on call or interrupt, pop on return (an interrupt replaces it)
  assign do_push = take || (STEP_I.valid && STEP_I.op == PCVEC_OP_CALL);
  assign do_pop  = !take && STEP_I.valid && STEP_I.op == PCVEC_OP_RET;

  // next program counter
  always_comb begin
    pc_d = pc_q;
    if (take) begin
      pc_d = vec;
    end else if (STEP_I.valid) begin
      unique case (STEP_I.op)
        PCVEC_OP_NEXT: pc_d = pc_inc;
        PCVEC_OP_JUMP: pc_d = branch;
        PCVEC_OP_CALL: pc_d = branch;
        PCVEC_OP_RET:  pc_d = stack_q[sp_q - 4'h1];
        PCVEC_OP_HOLD: pc_d = pc_q;
        default:       pc_d = pc_inc;   // illegal op code: step on
      endcase
    end
  end

  // program counter; either reset forces the reset vector
  always_ff @(posedge CLOCK_I) begin
    if (sys_rst) begin
      pc_q <= RESET_VECTOR;
    end else begin
      pc_q <= pc_d;
    end
  end

  // page register; the top nibble bit has no page behind it
  always_ff @(posedge CLOCK_I) begin
    if (sys_rst) begin
      page_q <= PAGE_RESET;
    end else if (STEP_I.valid && STEP_I.page_wr) begin
      page_q <= STEP_I.page_reg ? STEP_I.page_data[PAGE_W-1:0]
                                : STEP_I.page_imm[PAGE_W-1:0];
    end
  end

  // return stack as a circular buffer: pushing past sixteen overwrites
  // the oldest entry, so depth never exceeds sixteen
  always_ff @(posedge CLOCK_I) begin
    if (do_push) begin
      // on interrupt the saved address is the jump target for a jump, else the next sequential word
      stack_q[sp_q] <= take ? pc_d_seq(STEP_I, pc_inc, branch, pc_q)
                            : pc_inc;
    end
  end

  // return address when an interrupt pre-empts a step at a boundary
  function automatic logic [PC_W-1:0] pc_d_seq(
    input pcvec_step_t     s,
    input logic [PC_W-1:0] inc,
    input logic [PC_W-1:0] br,
    input logic [PC_W-1:0] cur
  );
    logic [PC_W-1:0] r;
    r = inc;
    unique case (s.op)
      PCVEC_OP_JUMP: r = br;
      PCVEC_OP_HOLD: r = cur;
      default:       r = inc;
    endcase
    return r;
  endfunction

  // stack pointer and level count
  always_ff @(posedge CLOCK_I) begin
    if (sys_rst) begin
      sp_q    <= '0;
      level_q <= '0;
    end else if (do_push) begin
      sp_q    <= sp_q + 4'h1;
      if (level_q != 5'(STACK_DEPTH)) begin
        level_q <= level_q + 5'h01;
      end
    end else if (do_pop) begin
      sp_q    <= sp_q - 4'h1;
      if (level_q != 5'h00) begin
        level_q <= level_q - 5'h01;
      end
    end
  end

  // take pulse, registered on the same edge that loads the vector
  always_ff @(posedge CLOCK_I) begin
    if (sys_rst) begin
      taken_q <= 1'b0;
    end else begin
      taken_q <= take;
    end
  end

  // outputs, all from flops
  assign PC_O                      = pc_q;
  assign INSTRUCTION_PAGE_SELECT_O = page_q;
  assign EVENT_FLAG_BITS_O         = flag_q;
  assign IRQ_TAKEN_O               = taken_q;
  assign STACK_LEVEL_O             = level_q;

  // checks

  chk_reset_vector: assert property (
    @(posedge CLOCK_I)
    !RSTN_I |=> pc_q == RESET_VECTOR)
    else $error("pc not at reset vector after reset");

  chk_vector_load: assert property (
    @(posedge CLOCK_I) disable iff (sys_rst)
    take && pending[SRC_FAST_DIV] |=> pc_q == 14'h0004)
    else $error("fast divider vector wrong");

  // slow divider wins only once the three higher sources are quiet
  chk_slow_vector: assert property (
    @(posedge CLOCK_I) disable iff (sys_rst)
    take && pending[SRC_SLOW_DIV] && (pending & 5'h07) == 5'h00
      |=> pc_q == 14'h0014)
    else $error("slow divider vector wrong");

  chk_prio_order: assert property (
    @(posedge CLOCK_I) disable iff (sys_rst)
    take && pending[SRC_TIMER0] && !pending[SRC_FAST_DIV]
      |=> pc_q == 14'h0008)
    else $error("timer 0 should win over lower sources");

  chk_gate_enable: assert property (
    @(posedge CLOCK_I) disable iff (sys_rst)
    (flag_q & INTERRUPT_ENABLE_BITS_I) == '0 |-> !take)
    else $error("interrupt taken without enabled flag");

  chk_jump_page: assert property (
    @(posedge CLOCK_I) disable iff (sys_rst)
    !take && STEP_I.valid && STEP_I.op == PCVEC_OP_JUMP
      |=> pc_q[PC_W-1:PAGE_OFS_W] == $past(page_q))
    else $error("jump left the selected page");

  chk_call_return: assert property (
    @(posedge CLOCK_I) disable iff (sys_rst)
    !take && STEP_I.valid && STEP_I.op == PCVEC_OP_CALL
      ##1 !take && STEP_I.valid && STEP_I.op == PCVEC_OP_RET
      |=> pc_q == $past(pc_q, 2) + 14'h0001)
    else $error("return did not resume after call");

  chk_level_bound: assert property (
    @(posedge CLOCK_I) disable iff (sys_rst)
    level_q <= 5'h10)
    else $error("stack level above sixteen");

  // a hold step keeps the counter even while a source is pending
  chk_boundary_take: assert property (
    @(posedge CLOCK_I) disable iff (sys_rst)
    STEP_I.valid && STEP_I.op == PCVEC_OP_HOLD
      |=> pc_q == $past(pc_q) && !taken_q)
    else $error("interrupt taken off a boundary");

  // a plain step pre-empted by an interrupt must resume one word on
  chk_irq_return: assert property (
    @(posedge CLOCK_I) disable iff (sys_rst)
    take && STEP_I.op == PCVEC_OP_NEXT
      |=> stack_q[sp_q - 4'h1] == $past(pc_q) + 14'h0001)
    else $error("interrupt saved a wrong return address");

  chk_port_pin: assert property (
    @(posedge CLOCK_I) disable iff (sys_rst)
    |port_hit |=> flag_q[SRC_PORT])
    else $error("port pin edge lost");

endmodule // pcvec_core

// file: hdl/pcvec_pkg.sv
// shared constants and carriers for program sequencing and vectoring
// assumes a single system clock; no software-visible registers here
package pcvec_pkg;

  // address space
  localparam int unsigned PC_W        = 14;       // instruction address width
  localparam int unsigned PAGE_W      = 3;        // page select width
  localparam int unsigned PAGE_OFS_W  = 11;       // 2048 words per page
  localparam int unsigned STACK_DEPTH = 16;       // saved return levels
  localparam int unsigned SP_W        = 4;        // stack index width
  localparam int unsigned NUM_IRQ     = 5;        // interrupt sources
  localparam int unsigned PORT_W      = 4;        // input-only port pins

  // reset values
  localparam logic [PC_W-1:0]   RESET_VECTOR = 14'h0000;
  localparam logic [PAGE_W-1:0] PAGE_RESET   = 3'h0;

  // vector table, index = priority order (0 serves first)
  localparam logic [PC_W-1:0] VEC_FAST_DIV = 14'h0004;
  localparam logic [PC_W-1:0] VEC_TIMER0   = 14'h0008;
  localparam logic [PC_W-1:0] VEC_PORT     = 14'h000c;
  localparam logic [PC_W-1:0] VEC_SLOW_DIV = 14'h0014;
  localparam logic [PC_W-1:0] VEC_TIMER1   = 14'h0020;

  // source bit positions in flag and enable vectors
  localparam int unsigned SRC_FAST_DIV = 0;
  localparam int unsigned SRC_TIMER0   = 1;
  localparam int unsigned SRC_PORT     = 2;
  localparam int unsigned SRC_SLOW_DIV = 3;
  localparam int unsigned SRC_TIMER1   = 4;

  // sequencing operation requested by the decoder for this instruction
  typedef enum logic [2:0] {
    PCVEC_OP_NEXT = 3'h0,  // plain increment
    PCVEC_OP_JUMP = 3'h1,  // jump into selected page
    PCVEC_OP_CALL = 3'h2,  // call into selected page
    PCVEC_OP_RET  = 3'h3,  // return from call or interrupt
    PCVEC_OP_HOLD = 3'h4   // stay (multi-cycle instruction)
  } pcvec_op_t;

  // one instruction step from the decoder
  typedef struct packed {
    logic                  valid;      // boundary: instruction completes
    pcvec_op_t             op;         // sequencing operation
    logic [PAGE_OFS_W-1:0] target;     // in-page destination offset
    logic                  page_wr;    // move to page register
    logic                  page_reg;   // source: 1 data register, 0 imm
    logic [3:0]            page_imm;   // immediate operand nibble
    logic [3:0]            page_data;  // data register nibble
  } pcvec_step_t;

endpackage : pcvec_pkg

// file: bench/tb_program_counter_vectoring.sv
// self-checking bench for the program sequencing and vectoring core
// assumes the core alone, one 10 MHz clock, bench drives every port
`timescale 1ns/10ps

module tb_program_counter_vectoring;
  import pcvec_pkg::*;

  // clock, resets and stimulus registers
  logic                CLOCK_I;
  logic                RSTN_I;
  logic                pin_n_q;    // external reset pin
  pcvec_step_t         step_q;     // decoder step
  logic [NUM_IRQ-1:0]  evt_q;      // event pulses by source bit
  logic [PORT_W-1:0]   pins_q;     // input-only port pins
  logic [PORT_W-1:0]   pen_q;      // per-pin enable
  logic [NUM_IRQ-1:0]  en_q;       // per-source enable
  logic [NUM_IRQ-1:0]  clr_q;      // flag clear pulses
  // design outputs
  logic [PC_W-1:0]     pc;
  logic [PAGE_W-1:0]   page;
  logic [NUM_IRQ-1:0]  flags;
  logic                taken;
  logic [SP_W:0]       level;
  // reference model state
  logic [PC_W-1:0]     exp_pc;
  logic [PAGE_W-1:0]   page_exp;
  logic [NUM_IRQ-1:0]  flags_exp;
  logic [PC_W-1:0]     stk[$];     // return addresses, newest last
  int                  failures;
  int                  samples_checked;
  int                  i;
  logic [31:0]         r;

  pcvec_core i_pcvec_core (
    .CLOCK_I                   (CLOCK_I),
    .RSTN_I                    (RSTN_I),
    .RESET_PIN_N_I             (pin_n_q),
    .STEP_I                    (step_q),
    .FAST_DIV_EVT_I            (evt_q[SRC_FAST_DIV]),
    .SLOW_DIV_EVT_I            (evt_q[SRC_SLOW_DIV]),
    .TIMER0_EVT_I              (evt_q[SRC_TIMER0]),
    .TIMER1_EVT_I              (evt_q[SRC_TIMER1]),
    .INTERRUPT_INPUT_PORT_I    (pins_q),
    .PORT_PIN_EN_I             (pen_q),
    .INTERRUPT_ENABLE_BITS_I   (en_q),
    .EVENT_FLAG_CLR_I          (clr_q),
    .PC_O                      (pc),
    .INSTRUCTION_PAGE_SELECT_O (page),
    .EVENT_FLAG_BITS_O         (flags),
    .IRQ_TAKEN_O               (taken),
    .STACK_LEVEL_O             (level)
  );

  // free-running system clock
  initial begin
    CLOCK_I = 1'b0;
    forever #50 CLOCK_I = ~CLOCK_I;
  end

  // compare and count; an unknown bit matches only an unknown bit
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      failures++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  // single place where the run ends
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // vector address expected for a source index
  function automatic logic [PC_W-1:0] vec_of(input int k);
    case (k)
      0: return VEC_FAST_DIV;
      1: return VEC_TIMER0;
      2: return VEC_PORT;
      3: return VEC_SLOW_DIV;
      default: return VEC_TIMER1;
    endcase
  endfunction

  // model push; the oldest entry falls off past sixteen
  task automatic push(input logic [PC_W-1:0] v);
    stk.push_back(v);
    if (stk.size() > STACK_DEPTH) begin
      stk.delete(0);
    end
  endtask

  // one step taken at the next edge, then idle, sampled after the edge
  task automatic issue(input pcvec_step_t s);
    @(posedge CLOCK_I);
    step_q <= s;
    @(posedge CLOCK_I);
    step_q <= '0;
    #1;
  endtask

  task automatic do_step(input pcvec_op_t op, input logic [10:0] tgt);
    pcvec_step_t s;
    s = '0;
    s.valid = 1'b1;
    s.op = op;
    s.target = tgt;
    case (op)
      PCVEC_OP_JUMP: exp_pc = {page_exp, tgt};
      PCVEC_OP_CALL: begin
        push(exp_pc + 14'h1);
        exp_pc = {page_exp, tgt};
      end
      PCVEC_OP_RET: exp_pc = stk.pop_back();
      PCVEC_OP_HOLD: exp_pc = exp_pc;
      default: exp_pc = exp_pc + 14'h1;
    endcase
    issue(s);
    check(pc, exp_pc);
    check(level, stk.size());
  endtask

  // page move; the unused source holds the inverse to catch a wrong pick
  task automatic set_page(input logic [3:0] v, input logic from_reg);
    pcvec_step_t s;
    s = '0;
    s.valid = 1'b1;
    s.op = PCVEC_OP_NEXT;
    s.page_wr = 1'b1;
    s.page_reg = from_reg;
    s.page_imm = from_reg ? ~v : v;
    s.page_data = from_reg ? v : ~v;
    page_exp = v[2:0];
    exp_pc = exp_pc + 14'h1;
    issue(s);
    check(page, page_exp);
  endtask

  // call and return on back-to-back edges; resumes after the call
  task automatic call_ret(input logic [10:0] tgt);
    pcvec_step_t s;
    s = '0;
    s.valid = 1'b1;
    s.op = PCVEC_OP_CALL;
    s.target = tgt;
    @(posedge CLOCK_I);
    step_q <= s;
    s.op = PCVEC_OP_RET;
    @(posedge CLOCK_I);
    step_q <= s;
    #1;
    check(pc, {page_exp, tgt});
    @(posedge CLOCK_I);
    step_q <= '0;
    #1;
    exp_pc = exp_pc + 14'h1;
    check(pc, exp_pc);
    check(level, stk.size());
  endtask

  // plain step that must be replaced by the best enabled source
  task automatic take_irq();
    pcvec_step_t s;
    int k;
    s = '0;
    s.valid = 1'b1;
    s.op = PCVEC_OP_NEXT;
    k = 0;
    while (k < 4 && !(flags_exp[k] & en_q[k])) k++;
    push(exp_pc + 14'h1);
    exp_pc = vec_of(k);
    flags_exp[k] = 1'b0;
    issue(s);
    check(pc, exp_pc);
    check(taken, 1'b1);
    check(flags, flags_exp);
    check(level, stk.size());
  endtask

  task automatic reset_dut();
    @(posedge CLOCK_I);
    RSTN_I <= 1'b0;
    repeat (2) @(posedge CLOCK_I);
    RSTN_I <= 1'b1;
    // the pin synchroniser refills first; steps before that are lost
    repeat (2) @(posedge CLOCK_I);
    #1;
    stk.delete();
    exp_pc = RESET_VECTOR;
    page_exp = PAGE_RESET;
    flags_exp = '0;
    check(pc, exp_pc);
    check(page, page_exp);
    check(level, 0);
    check(flags, flags_exp);
  endtask

  // watchdog; the whole sequence needs a few hundred cycles
  initial begin
    repeat (20000) @(posedge CLOCK_I);
    failures++;
    print_verdict();
  end

  // main sequence
  initial begin
    failures = 0;
    samples_checked = 0;
    RSTN_I = 1'b0;
    pin_n_q = 1'b1;
    step_q = '0;
    evt_q = '0;
    pins_q = 4'hf;
    pen_q = 4'hf;
    en_q = '0;
    clr_q = '0;
    void'($urandom(32'h2adad81b));
    reset_dut();
    // random page moves, jumps and increments
    repeat (24) begin
      r = $urandom;
      set_page(r[3:0], r[4]);
      do_step(PCVEC_OP_JUMP, r[15:5]);
      do_step(PCVEC_OP_NEXT, r[26:16]);
    end
    // last word of the top page wraps to zero
    set_page(4'hf, 1'b1);
    do_step(PCVEC_OP_JUMP, 11'h7ff);
    do_step(PCVEC_OP_NEXT, 11'h0);
    // reset pin forces the reset vector
    do_step(PCVEC_OP_JUMP, 11'h123);
    pin_n_q <= 1'b0;
    repeat (5) @(posedge CLOCK_I);
    #1;
    check(pc, RESET_VECTOR);
    @(posedge CLOCK_I);
    pin_n_q <= 1'b1;
    repeat (4) @(posedge CLOCK_I);
    reset_dut();
    // seventeen nested calls lose the oldest return address
    for (i = 0; i < 17; i++) do_step(PCVEC_OP_CALL, 11'(i * 16 + 3));
    for (i = 0; i < 16; i++) do_step(PCVEC_OP_RET, 11'h0);
    call_ret(11'h2a5);
    // all five pending while disabled, then served by priority
    reset_dut();
    evt_q <= 5'h1b;
    pins_q <= 4'he;
    @(posedge CLOCK_I);
    evt_q <= '0;
    repeat (6) @(posedge CLOCK_I);
    #1;
    flags_exp = 5'h1f;
    check(flags, flags_exp);
    do_step(PCVEC_OP_NEXT, 11'h0);
    check(taken, 1'b0);
    en_q <= 5'h1f;
    // a hold step is no boundary: pending sources must wait
    do_step(PCVEC_OP_HOLD, 11'h0);
    check(taken, 1'b0);
    repeat (5) take_irq();
    for (i = 0; i < 5; i++) do_step(PCVEC_OP_RET, 11'h0);
    // each port pin alone, others masked per pin
    en_q <= '0;
    pins_q <= 4'hf;
    @(posedge CLOCK_I);
    for (i = 0; i < 4; i++) begin
      pen_q <= 4'(1 << i);
      pins_q <= ~4'(1 << ((i + 1) % 4));
      repeat (6) @(posedge CLOCK_I);
      #1;
      check(flags, 5'h00);
      pins_q <= ~4'(1 << i);
      repeat (6) @(posedge CLOCK_I);
      #1;
      check(flags, 5'h04);
      clr_q <= 5'h04;
      pins_q <= 4'hf;
      @(posedge CLOCK_I);
      clr_q <= '0;
      repeat (2) @(posedge CLOCK_I);
      #1;
      check(flags, 5'h00);
    end
    print_verdict();
  end

endmodule // tb_program_counter_vectoring
